// *** logic/dtcc_map.svh ***
`ifndef DTCC_MAP_SVH
`define DTCC_MAP_SVH

// array shape
`define DTCC_NUM_CH 16
`define DTCC_NUM_PAIR 8
`define DTCC_CH_SEL_W 4
`define DTCC_TW 16

// timer values
`define DTCC_TIMER_RST 16'h0000
`define DTCC_TIMER_MAX 16'hFFFF
`define DTCC_CC_RST 16'h0000

// prescaler: division by 2**n, n = 0 .. DIVS-1
`define DTCC_PRESC_DIVS 8
`define DTCC_PRESC_SEL_W 3
`define DTCC_PRESC_CNT_W 7

// staggered operation: one timer step per eight system cycles at prescaler division 1, none at higher prescaler divisions
`define DTCC_STAG_W 3
`define DTCC_STAG_LAST 3'h7

`endif

// *** logic/dtcc_pkg.sv ***
package dtcc_pkg;

	// per-channel operating mode
	typedef enum logic [2:0] {
		CC_OFF,
		CC_CAP_RISE,
		CC_CAP_FALL,
		CC_CAP_BOTH,
		CC_CMP_M0,
		CC_CMP_M1,
		CC_CMP_M2,
		CC_CMP_M3
	} dtcc_mode_t;

	// timer count source
	typedef enum logic [1:0] {
		TB_SRC_PRESC,
		TB_SRC_NEIGH,
		TB_SRC_EXT
	} dtcc_src_t;

endpackage

// *** logic/dtcc_tb_if.sv ***
`timescale 1ns/100ps
interface dtcc_tb_if #(parameter int TW = 16);
	logic [TW-1:0] value; // current timer count
	logic ovf; // one-cycle pulse, value has just been reloaded
	logic fresh; // one-cycle pulse, value has just changed
	modport src (output value, output ovf, output fresh);
	modport snk (input value, input ovf, input fresh);
endinterface

// *** logic/dtcc_prescaler.sv ***
`timescale 1ns/100ps
`include "dtcc_map.svh"
module dtcc_prescaler #(
	parameter int DIVS = `DTCC_PRESC_DIVS,
	parameter int CW = `DTCC_PRESC_CNT_W
) (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset, active low
	output logic [DIVS-1:0] tick // tick[n]: one pulse per 2**n cycles
);
	logic [CW-1:0] cnt;

	// free-running divider shared by both timers keeps their ticks aligned
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
		end else begin
			cnt <= CW'(cnt + 1'b1);
		end
	end

	// tick n is high the cycle after the low n counter bits are all ones
	for (genvar g = 0; g < DIVS; g++) begin : gDiv
		localparam logic [CW:0] MASK = (CW+1)'((1 << g) - 1);
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				tick[g] <= 1'b0;
			end else begin
				tick[g] <= ((cnt & MASK[CW-1:0]) == MASK[CW-1:0]);
			end
		end
	end
endmodule

// *** logic/dtcc_timebase.sv ***
`timescale 1ns/100ps
`include "dtcc_map.svh"
module dtcc_timebase #(
	parameter int TW = `DTCC_TW,
	parameter int DIVS = `DTCC_PRESC_DIVS
) (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic runEn, // timer runs
	input wire dtcc_pkg::dtcc_src_t clkSrc, // count source
	input wire logic [`DTCC_PRESC_SEL_W-1:0] prescSel, // prescaler division
	input wire logic [DIVS-1:0] prescTick, // prescaler ticks
	input wire logic neighOvf, // neighbour_toggle_timer over/underflow pulse
	input wire logic extCount, // external count input level
	input wire logic stagGate, // step allowed this cycle
	input wire logic [TW-1:0] reload, // reload value
	input wire logic loadWe, // direct timer write strobe
	input wire logic [TW-1:0] loadVal, // direct timer write data
	dtcc_tb_if.src tb // value and events to the channel array
);
	import dtcc_pkg::*;

	logic extPrev;
	logic srcTick;
	logic countTick;
	logic [TW-1:0] value;
	logic ovf;
	logic fresh;
	localparam logic [TW-1:0] TMAX = `DTCC_TIMER_MAX;

	// count source selection; staggered mode may swallow external edges
	always_comb begin
		case (clkSrc)
			TB_SRC_PRESC: srcTick = prescTick[prescSel];
			TB_SRC_NEIGH: srcTick = neighOvf;
			TB_SRC_EXT: srcTick = extCount & ~extPrev;
			default: srcTick = 1'b0;
		endcase
		countTick = runEn & srcTick & stagGate;
	end

	// external input edge memory
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			extPrev <= 1'b0;
		end else begin
			extPrev <= extCount;
		end
	end

	// up-counter, reloads on overflow; a software write takes priority
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			value <= `DTCC_TIMER_RST;
		end else if (loadWe) begin
			value <= loadVal;
		end else if (countTick) begin
			if (value == TMAX) begin
				value <= reload;
			end else begin
				value <= TW'(value + 1'b1);
			end
		end
	end

	// event pulses line up with the value they describe
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ovf <= 1'b0;
			fresh <= 1'b0;
		end else begin
			ovf <= countTick & (value == TMAX) & ~loadWe;
			fresh <= countTick | loadWe;
		end
	end

	assign tb.value = value;
	assign tb.ovf = ovf;
	assign tb.fresh = fresh;
endmodule

// *** logic/dtcc_top.sv ***
`timescale 1ns/100ps
`include "dtcc_map.svh"
module dtcc_top #(
	parameter int NCH = `DTCC_NUM_CH,
	parameter int TW = `DTCC_TW,
	parameter int DIVS = `DTCC_PRESC_DIVS
) (
	input wire logic clk_sys, // system clock, 200 MHz
	input wire logic rstn, // async reset, active low
	input wire logic staggered, // staggered operation select
	input wire logic runA, // time_base_a runs
	input wire dtcc_pkg::dtcc_src_t srcA, // time_base_a count source
	input wire logic [`DTCC_PRESC_SEL_W-1:0] prescA, // time_base_a division
	input wire logic [TW-1:0] reloadA, // time_base_a reload value
	input wire logic loadWeA, // time_base_a write strobe
	input wire logic [TW-1:0] loadValA, // time_base_a write data
	input wire logic runB, // time_base_b runs
	input wire dtcc_pkg::dtcc_src_t srcB, // time_base_b count source
	input wire logic [`DTCC_PRESC_SEL_W-1:0] prescB, // time_base_b division
	input wire logic [TW-1:0] reloadB, // time_base_b reload value
	input wire logic loadWeB, // time_base_b write strobe
	input wire logic [TW-1:0] loadValB, // time_base_b write data
	input wire logic neighOvf, // neighbour_toggle_timer overflow pulse
	input wire logic extCount, // external count input
	input wire dtcc_pkg::dtcc_mode_t [NCH-1:0] chanMode, // per-channel mode
	input wire logic [NCH-1:0] chanTbSel, // 0 time_base_a, 1 time_base_b
	input wire logic [NCH-1:0] singleEv, // single-event option, low re-arms
	input wire logic [NCH/2-1:0] dblPair, // pair k: channels 2k, 2k+1 share pin 2k
	input wire logic ccWe, // channel register write strobe
	input wire logic [`DTCC_CH_SEL_W-1:0] ccSel, // channel register select
	input wire logic [TW-1:0] ccWrData, // channel register write data
	input wire logic [NCH-1:0] pinIn, // channel pin input levels
	output logic [NCH-1:0] pinOut, // channel pin output levels
	output logic [NCH-1:0] pinOe_n, // pin output enable, low drives
	output logic [NCH-1:0] irqReq, // per-channel request pulses
	output logic [NCH-1:0] seDone, // single event consumed
	output logic [NCH-1:0][TW-1:0] ccValue, // channel registers
	output logic [TW-1:0] tbValueA, // time_base_a copy
	output logic [TW-1:0] tbValueB // time_base_b copy
);
	import dtcc_pkg::*;

	logic [`DTCC_STAG_W-1:0] slot;
	logic stagGate;
	logic [DIVS-1:0] prescTick;
	logic [NCH-1:0] pinPrev;
	logic [NCH-1:0] trig;
	logic [NCH-1:0] cmpEvt;
	logic [NCH-1:0] chOvf;
	logic [NCH-1:0] periodHit;

	dtcc_tb_if #(.TW(TW)) tbA ();
	dtcc_tb_if #(.TW(TW)) tbB ();

	// next pin level for a channel driving its own pin
	function automatic logic nextPin(dtcc_mode_t m, logic cur, logic evt, logic ovf);
		logic r;
		r = cur;
		if (m == CC_CMP_M1 && evt) begin
			r = ~cur;
		end else if (m == CC_CMP_M3) begin
			if (evt) begin
				r = 1'b1;
			end else if (ovf) begin
				r = 1'b0;
			end
		end
		return r;
	endfunction

	// stagger slot; the timers step only in the last slot when staggered
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			slot <= '0;
		end else begin
			slot <= `DTCC_STAG_W'(slot + 1'b1);
		end
	end
	assign stagGate = ~staggered | (slot == `DTCC_STAG_LAST);

	dtcc_prescaler #(.DIVS(DIVS)) uPresc (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.tick(prescTick)
	);

	dtcc_timebase #(.TW(TW), .DIVS(DIVS)) uTbA (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.runEn(runA),
		.clkSrc(srcA),
		.prescSel(prescA),
		.prescTick(prescTick),
		.neighOvf(neighOvf),
		.extCount(extCount),
		.stagGate(stagGate),
		.reload(reloadA),
		.loadWe(loadWeA),
		.loadVal(loadValA),
		.tb(tbA)
	);

	dtcc_timebase #(.TW(TW), .DIVS(DIVS)) uTbB (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.runEn(runB),
		.clkSrc(srcB),
		.prescSel(prescB),
		.prescTick(prescTick),
		.neighOvf(neighOvf),
		.extCount(extCount),
		.stagGate(stagGate),
		.reload(reloadB),
		.loadWe(loadWeB),
		.loadVal(loadValB),
		.tb(tbB)
	);

	// timer copies for software reads
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tbValueA <= `DTCC_TIMER_RST;
			tbValueB <= `DTCC_TIMER_RST;
		end else begin
			tbValueA <= tbA.value;
			tbValueB <= tbB.value;
		end
	end

	// pin edge memory, pins are taken as synchronous
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pinPrev <= '0;
		end else begin
			pinPrev <= pinIn;
		end
	end

	for (genvar i = 0; i < NCH; i++) begin : gCh
		logic [TW-1:0] tv;
		logic tf;
		logic isCmp;
		logic onceMode;
		logic rise;
		logic fall;

		// timer assignment per channel
		assign tv = chanTbSel[i] ? tbB.value : tbA.value;
		assign tf = chanTbSel[i] ? tbB.fresh : tbA.fresh;
		assign chOvf[i] = chanTbSel[i] ? tbB.ovf : tbA.ovf;
		assign isCmp = chanMode[i][2];
		assign onceMode = (chanMode[i] == CC_CMP_M2) || (chanMode[i] == CC_CMP_M3);
		assign rise = pinIn[i] & ~pinPrev[i];
		assign fall = ~pinIn[i] & pinPrev[i];

		// capture trigger edge selection
		always_comb begin
			case (chanMode[i])
				CC_CAP_RISE: trig[i] = rise;
				CC_CAP_FALL: trig[i] = fall;
				CC_CAP_BOTH: trig[i] = rise | fall;
				default: trig[i] = 1'b0;
			endcase
		end

		// a match is judged only when the timer has just stepped or been written, so a held
		// timer value (slow prescaler) does not fire the channel repeatedly
		assign cmpEvt[i] = isCmp & tf & (tv == ccValue[i])
			& ~(singleEv[i] & seDone[i])
			& ~(onceMode & periodHit[i] & ~chOvf[i]);

		// channel register: capture wins over a software write
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				ccValue[i] <= `DTCC_CC_RST;
			end else if (trig[i]) begin
				ccValue[i] <= tv;
			end else if (ccWe && (ccSel == `DTCC_CH_SEL_W'(i))) begin
				ccValue[i] <= ccWrData;
			end
		end

		// once-per-period memory, restarted by the assigned timer overflow
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				periodHit[i] <= 1'b0;
			end else if (!onceMode) begin
				periodHit[i] <= 1'b0;
			end else if (chOvf[i]) begin
				periodHit[i] <= cmpEvt[i];
			end else if (cmpEvt[i]) begin
				periodHit[i] <= 1'b1;
			end
		end

		// single-event latch; re-armed by software dropping the option
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				seDone[i] <= 1'b0;
			end else if (!singleEv[i]) begin
				seDone[i] <= 1'b0;
			end else if (cmpEvt[i]) begin
				seDone[i] <= 1'b1;
			end
		end

		// request on every capture and every compare event
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				irqReq[i] <= 1'b0;
			end else begin
				irqReq[i] <= trig[i] | cmpEvt[i];
			end
		end
	end

	// pin ownership per pair; in double mode the odd pin is released
	for (genvar k = 0; k < NCH/2; k++) begin : gPair
		localparam int A = 2 * k;
		localparam int B = 2 * k + 1;
		logic drvA;
		logic drvB;

		assign drvA = dblPair[k] | (chanMode[A] == CC_CMP_M1) | (chanMode[A] == CC_CMP_M3);
		assign drvB = ~dblPair[k] & ((chanMode[B] == CC_CMP_M1) | (chanMode[B] == CC_CMP_M3));

		// even pin: shared toggle in double mode, own mode otherwise
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				pinOut[A] <= 1'b0;
			end else if (dblPair[k]) begin
				if (cmpEvt[A] ^ cmpEvt[B]) begin
					pinOut[A] <= ~pinOut[A];
				end
			end else begin
				pinOut[A] <= nextPin(chanMode[A], pinOut[A], cmpEvt[A], chOvf[A]);
			end
		end

		// odd pin follows its own mode only outside double mode, holds in double mode
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				pinOut[B] <= 1'b0;
			end else if (!dblPair[k]) begin
				pinOut[B] <= nextPin(chanMode[B], pinOut[B], cmpEvt[B], chOvf[B]);
			end
		end

		// output enables, low while the channel owns its pin as an output
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				pinOe_n[A] <= 1'b1;
				pinOe_n[B] <= 1'b1;
			end else begin
				pinOe_n[A] <= ~drvA;
				pinOe_n[B] <= ~drvB;
			end
		end
	end
endmodule

// *** dv/dtcc_pin_model.sv ***
`timescale 1ns/100ps
module dtcc_pin_model (
	input wire logic [15:0] pinOut, // block pin levels
	input wire logic [15:0] pinOe_n, // low where the block drives
	input wire logic [15:0] capLvl, // level the outside source offers
	output logic [15:0] pinIn // resolved wire level
);
	// the block wins where it drives; elsewhere the outside source sets the wire
	assign pinIn = (pinOe_n & capLvl) | (~pinOe_n & pinOut);
endmodule

// *** dv/dtcc_checker.sv ***
`timescale 1ns/100ps
module dtcc_checker #(
	parameter int NCH = 16,
	parameter int TW = 16
) (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic staggered, // staggered select
	input wire logic runA, // timer a runs
	input wire dtcc_pkg::dtcc_src_t srcA, // timer a source
	input wire logic [2:0] prescA, // timer a division
	input wire logic [TW-1:0] reloadA, // timer a reload
	input wire logic loadWeA, // timer a write
	input wire logic runB, // timer b runs
	input wire logic loadWeB, // timer b write
	input wire dtcc_pkg::dtcc_mode_t [NCH-1:0] chanMode, // modes
	input wire logic [NCH-1:0] chanTbSel, // timer select
	input wire logic [NCH-1:0] singleEv, // single-event option
	input wire logic [NCH/2-1:0] dblPair, // pair joins
	input wire logic [NCH-1:0] pinIn, // pin levels in
	input wire logic [NCH-1:0] pinOut, // pin levels out
	input wire logic [NCH-1:0] pinOe_n, // output enables
	input wire logic [NCH-1:0] irqReq, // request pulses
	input wire logic [NCH-1:0] seDone, // single event used
	input wire logic [NCH-1:0][TW-1:0] ccValue, // channel registers
	input wire logic [TW-1:0] tbValueA, // timer a copy
	input wire logic [TW-1:0] tbValueB // timer b copy
);
	import dtcc_pkg::*;
	logic [2:0] up;
	logic fast;
	logic frozenB;
	// settle count: prescaler ticks are not there right after reset
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			up <= 3'h0;
		end else if (up != 3'h7) begin
			up <= up + 3'h1;
		end
	end
	// timer a steps every cycle; timer b cannot move
	assign fast = runA && srcA == TB_SRC_PRESC && prescA == 3'h0 && !staggered && !loadWeA && up == 3'h7;
	assign frozenB = !runB && !loadWeB;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_capRise;
		chanMode[4] == CC_CAP_RISE && chanTbSel[4] && frozenB && $past(frozenB, 3) && $rose(pinIn[4]);
	endsequence
	sequence s_capFall;
		chanMode[4] == CC_CAP_RISE && $fell(pinIn[4]);
	endsequence
	a_timer_step: assert property ($past(fast, 2) |-> tbValueA == (($past(tbValueA) == 16'hFFFF) ?
		$past(reloadA, 2) : $past(tbValueA) + 16'h1)) else $error("timer a step wrong");
	a_m3_clear: assert property (chanMode[2] == CC_CMP_M3 && $past(chanMode[2]) == CC_CMP_M3 &&
		!dblPair[1] && $past(fast, 2) && $past(tbValueA) == 16'hFFFF && !irqReq[2] |-> !pinOut[2])
		else $error("mode 3 pin not cleared on overflow");
	a_m0_match: assert property (irqReq[0] && chanMode[0] == CC_CMP_M0 && !chanTbSel[0] &&
		$past(chanMode[0]) == CC_CMP_M0 |-> tbValueA == $past(ccValue[0])) else $error("mode 0 irq off match");
	a_m1_toggle: assert property (chanMode[1] == CC_CMP_M1 && $past(chanMode[1]) == CC_CMP_M1 &&
		!dblPair[0] |-> irqReq[1] == (pinOut[1] != $past(pinOut[1]))) else $error("mode 1 toggle wrong");
	a_single_stop: assert property ($past(seDone[1]) && singleEv[1] && chanMode[1] >= CC_CMP_M0 |->
		!irqReq[1]) else $error("event after single event");
	a_se_rearm: assert property (!singleEv[1] |=> !seDone[1]) else $error("single event not re-armed");
	a_cap_rise: assert property (s_capRise |=> irqReq[4] && ccValue[4] == tbValueB)
		else $error("rising capture missed");
	a_cap_ignore: assert property (s_capFall |=> !irqReq[4]) else $error("falling edge captured");
	a_pin_release: assert property (chanMode[4] < CC_CMP_M0 && !dblPair[2] |=> pinOe_n[4])
		else $error("capture pin driven");
endmodule
bind dtcc_top dtcc_checker #(.NCH(NCH), .TW(TW)) u_chk (.clk_sys(clk_sys), .rstn(rstn),
	.staggered(staggered), .runA(runA), .srcA(srcA), .prescA(prescA), .reloadA(reloadA),
	.loadWeA(loadWeA), .runB(runB), .loadWeB(loadWeB), .chanMode(chanMode), .chanTbSel(chanTbSel),
	.singleEv(singleEv), .dblPair(dblPair), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
	.irqReq(irqReq), .seDone(seDone), .ccValue(ccValue), .tbValueA(tbValueA), .tbValueB(tbValueB));

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	import dtcc_pkg::*;
	logic clk_sys = 0, rstn = 0, staggered = 0, runA = 1, runB = 0, loadWeA = 0, loadWeB = 0;
	logic neighOvf = 0, extCount = 0, ccWe = 0;
	dtcc_src_t srcA = TB_SRC_PRESC, srcB = TB_SRC_EXT;
	logic [2:0] prescA = 3'h0, prescB = 3'h0;
	logic [15:0] reloadA = 16'hFFF0, reloadB = 16'h0000, loadValA = 16'h0000, loadValB = 16'h0000;
	logic [15:0] ccWrData = 16'h0000, chanTbSel = 16'h0010, singleEv = 16'h0000, capLvl = 16'h0000;
	logic [15:0] pinIn, pinOut, pinOe_n, irqReq, seDone, tbValueA, tbValueB;
	logic [7:0] dblPair = 8'h00;
	logic [3:0] ccSel = 4'h0;
	dtcc_mode_t [15:0] chanMode;
	logic [15:0][15:0] ccValue;
	int errCount = 0, samplesChecked = 0;
	int irqCnt[16], togCnt[16];
	// free-running system clock
	always #2.5 clk_sys = ~clk_sys;
	dtcc_top DUT (.clk_sys(clk_sys), .rstn(rstn), .staggered(staggered), .runA(runA), .srcA(srcA),
		.prescA(prescA), .reloadA(reloadA), .loadWeA(loadWeA), .loadValA(loadValA), .runB(runB),
		.srcB(srcB), .prescB(prescB), .reloadB(reloadB), .loadWeB(loadWeB), .loadValB(loadValB),
		.neighOvf(neighOvf), .extCount(extCount), .chanMode(chanMode), .chanTbSel(chanTbSel),
		.singleEv(singleEv), .dblPair(dblPair), .ccWe(ccWe), .ccSel(ccSel), .ccWrData(ccWrData),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n), .irqReq(irqReq), .seDone(seDone),
		.ccValue(ccValue), .tbValueA(tbValueA), .tbValueB(tbValueB));
	dtcc_pin_model u_pins (.pinOut(pinOut), .pinOe_n(pinOe_n), .capLvl(capLvl), .pinIn(pinIn));
	// compare a design value; x never matches
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errCount++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask
	// compare an event count
	task automatic chkn(input int got, input int exp);
		samplesChecked++;
		if (got != exp) begin
			errCount++;
			$display("BAD %0t count %0d expected %0d", $time, got, exp);
		end
	endtask
	// advance n cycles, tallying request pulses and pin toggles
	task automatic step(input int n);
		logic [15:0] last;
		repeat (n) begin
			last = pinOut;
			@(posedge clk_sys);
			#1;
			for (int i = 0; i < 16; i++) begin
				irqCnt[i] += (irqReq[i] === 1'b1);
				togCnt[i] += (pinOut[i] !== last[i]);
			end
		end
	endtask
	task automatic clr;
		foreach (irqCnt[i]) begin
			irqCnt[i] = 0;
			togCnt[i] = 0;
		end
	endtask
	task automatic off;
		for (int i = 0; i < 16; i++) chanMode[i] = CC_OFF;
	endtask
	// strobes get an idle edge after them so no two writes merge
	task automatic wr(input logic [3:0] ch, input logic [15:0] v);
		ccSel = ch;
		ccWrData = v;
		ccWe = 1;
		step(1);
		ccWe = 0;
		step(1);
	endtask
	task automatic ld(input logic b, input logic [15:0] v);
		if (b) begin
			loadValB = v;
			loadWeB = 1;
		end else begin
			loadValA = v;
			loadWeA = 1;
		end
		step(1);
		loadWeA = 0;
		loadWeB = 0;
		step(1);
	endtask
	// bounded wait for a timer a value
	task automatic waitv(input logic [15:0] v);
		int n = 0;
		while (tbValueA !== v && n < 40) begin
			step(1);
			n++;
		end
		chkn(n < 40, 1);
	endtask
	task automatic t_timer;
		logic [15:0] v;
		waitv(16'hFFFE);
		step(1);
		chk(tbValueA, 16'hFFFF);
		step(1);
		chk(tbValueA, 16'hFFF0);
		staggered = 1;
		step(3);
		v = tbValueA;
		step(8);
		chk(tbValueA, v == 16'hFFFF ? 16'hFFF0 : v + 16'h1);
		staggered = 0;
		runB = 1;
		ld(1, 16'h0100);
		repeat (3) begin
			extCount = 1;
			step(2);
			extCount = 0;
			step(2);
		end
		chk(tbValueB, 16'h0103);
		srcB = TB_SRC_NEIGH;
		repeat (2) begin
			neighOvf = 1;
			step(1);
			neighOvf = 0;
			step(2);
		end
		chk(tbValueB, 16'h0105);
		srcB = TB_SRC_PRESC;
		prescB = 3'h2;
		step(4);
		v = tbValueB;
		step(16);
		chk(tbValueB, v + 16'h4);
		runB = 0;
	endtask
	task automatic t_capture;
		dtcc_mode_t m[3] = '{CC_CAP_RISE, CC_CAP_FALL, CC_CAP_BOTH};
		int e[3] = '{1, 1, 2};
		ld(1, 16'h5A3C);
		for (int k = 0; k < 3; k++) begin
			chanMode[4] = m[k];
			wr(4'h4, 16'h0000);
			clr;
			capLvl[4] = 1;
			step(3);
			capLvl[4] = 0;
			step(3);
			chkn(irqCnt[4], e[k]);
			chk(ccValue[4], 16'h5A3C);
			chk(pinOe_n, 16'hFFFF);
		end
		off;
	endtask
	task automatic t_m0m2;
		wr(4'h0, 16'hFFF4);
		wr(4'h3, 16'hFFF4);
		chanMode[0] = CC_CMP_M0;
		chanMode[3] = CC_CMP_M2;
		step(2);
		clr;
		step(32);
		chkn(irqCnt[0], 2);
		chkn(irqCnt[3], 2);
		chkn(togCnt[0], 0);
		waitv(16'hFFF6);
		clr;
		ld(0, 16'hFFF2);
		step(6);
		chkn(irqCnt[0], 1);
		chkn(irqCnt[3], 0);
		off;
	endtask
	task automatic t_m1m3;
		wr(4'h1, 16'hFFF4);
		wr(4'h2, 16'hFFF8);
		chanMode[1] = CC_CMP_M1;
		chanMode[2] = CC_CMP_M3;
		step(2);
		chk(pinOe_n, 16'hFFF9);
		// start the window just after an overflow clear, so mode 3 sees set and clear twice
		waitv(16'hFFF0);
		clr;
		step(32);
		chkn(togCnt[1], 2);
		chkn(togCnt[2], 4);
		waitv(16'hFFFA);
		chk(pinOut & 16'h0004, 16'h0004);
		waitv(16'hFFF2);
		chk(pinOut & 16'h0004, 16'h0000);
		singleEv[1] = 1;
		clr;
		step(48);
		chkn(togCnt[1], 1);
		chk(seDone & 16'h0002, 16'h0002);
		singleEv[1] = 0;
		step(2);
		chk(seDone, 16'h0000);
		off;
	endtask
	task automatic t_double;
		wr(4'h0, 16'hFFF2);
		wr(4'h1, 16'hFFF9);
		dblPair = 8'h01;
		chanMode[0] = CC_CMP_M1;
		chanMode[1] = CC_CMP_M1;
		step(2);
		chk(pinOe_n, 16'hFFFE);
		clr;
		step(32);
		chkn(togCnt[0], 4);
		chkn(togCnt[1], 0);
	endtask
	task automatic finalReport;
		if (errCount == 0 && samplesChecked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// main sequence; timer a starts from the reload value, not from zero
	initial begin
		off;
		repeat (16) @(posedge clk_sys);
		#1 rstn = 1;
		ld(0, 16'hFFF0);
		t_timer;
		t_capture;
		t_m0m2;
		t_m1m3;
		t_double;
		finalReport;
	end
	// hang guard, about ten times the expected run
	initial begin
		#20000;
		errCount++;
		finalReport;
	end
endmodule
